//--- logic/pid_pkg.sv
// Package for the posted interrupt table entry decoder.
// Assumes a 128-bit entry image presented by the table fetch logic.
package pid_pkg;
    localparam int ENTRY_W = 128;
    localparam int RID_W = 16;
    // Entry field positions.
    localparam int PRESENT_BIT = 0;
    localparam int POSTING_MODE_BIT = 15;
    localparam int URGENT_BIT = 14;
    localparam int RSVD_LO_MSB = 13;
    localparam int RSVD_LO_LSB = 12;
    localparam int VECTOR_MSB = 23;
    localparam int VECTOR_LSB = 16;
    localparam int RSVD_MID_MSB = 37;
    localparam int RSVD_MID_LSB = 24;
    localparam int DESC_LO_MSB = 63;
    localparam int DESC_LO_LSB = 38;
    localparam int ORIG_ID_MSB = 79;
    localparam int ORIG_ID_LSB = 64;
    localparam int QUAL_MSB = 81;
    localparam int QUAL_LSB = 80;
    localparam int CHECK_MSB = 83;
    localparam int CHECK_LSB = 82;
    localparam int RSVD_HI_MSB = 95;
    localparam int RSVD_HI_LSB = 84;
    localparam int DESC_HI_MSB = 127;
    localparam int DESC_HI_LSB = 96;
    localparam int ADDR_ALIGN_BITS = 6;
    localparam int ADDR_W = 64;
    // Default host address width.
    localparam logic [6:0] ADDR_WIDTH_RESET = 7'h30;
    // Bus number fields of a requester-id or a bus-range identifier.
    localparam int BUS_MSB = 15;
    localparam int BUS_LSB = 8;
    localparam int LAST_BUS_MSB = 7;
    localparam int LAST_BUS_LSB = 0;

    typedef enum logic [1:0] {
        PID_CHECK_NONE = 2'b00,
        PID_CHECK_RID = 2'b01,
        PID_CHECK_BUS = 2'b10,
        PID_CHECK_RSVD = 2'b11
    } pid_check_type;

    typedef enum logic [1:0] {
        PID_RES_OK = 2'b00,
        PID_RES_BLOCKED = 2'b01,
        PID_RES_SRC_FAULT = 2'b10,
        PID_RES_FORMAT_FAULT = 2'b11
    } pid_result_type;
endpackage : pid_pkg

//--- logic/pid_entry_decode.sv
// Decoder for the posted-format interrupt table entry.
// Assumes entry and request arrive together, on the same clock, with valid.
`timescale 1ns/1ns
// Contract
// - Check type 01b: identifier is the sole allowed requester-id.
// - Under check 01b the qualifier picks the compared identifier bits.
// - Check type 10b: upper byte is first bus, lower byte last bus.
// - Bus check passes when first bus <= request bus <= last bus.
// - Identifier examined only for a valid entry with check 01b or 10b.
// - Descriptor address 31:6 from entry 63:38, low bits zero, valid only.
// - Bits 37:24 and 13:12 must be zero; checked only for valid entries.
// - Guest vector from entry 23:16, used only for valid entries.
// - Bit 15 set means posted; clear means remapped format.
// - Without posting support, bits 15 and 14 are reserved zero.
// - Bit 14 set marks the posted interrupt urgent.
// - Urgent evaluated only when valid and posting mode are both set.
// - Check type 00b verifies nothing; 11b is reserved.
// - Qualifier 00b all bits, 01b skip bit2, 10b bits2:1, 11b bits2:0.
// - An invalid entry blocks every request referencing it.
// - Address 63:32 from high field; bits above address width reserved.
module pid_entry_decode (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic req_valid_in,
    input wire logic [127:0] entry_in,
    input wire logic [15:0] requester_id_in,
    input wire logic posting_supported_cap_in,
    input wire logic [6:0] host_address_width_in,
    output logic res_valid_out,
    output logic [1:0] result_out,
    output logic posted_out,
    output logic remapped_out,
    output logic urgent_flag_out,
    output logic [7:0] guest_vector_out,
    output logic [63:0] post_desc_addr_out
);
    logic present;
    logic posting_mode_bit;
    logic urgent_flag;
    logic [1:0] origin_check_type;
    logic [1:0] origin_check_qualifier;
    logic [15:0] originator_identifier;
    logic [25:0] post_desc_addr_low;
    logic [31:0] post_desc_addr_high;
    logic [15:0] id_mask;
    logic [7:0] req_bus;
    logic [7:0] first_bus;
    logic [7:0] last_bus;
    logic rid_match;
    logic bus_in_range;
    logic src_ok;
    logic rsvd_bad;
    logic [63:0] addr_full;
    logic [63:0] width_mask;
    logic [7:0] guest_vector;
    logic deliver;
    logic post_ok;
    pid_pkg::pid_result_type res_d;
    logic res_valid_q;
    logic [1:0] result_q;
    logic posted_q;
    logic remapped_q;
    logic urgent_q;
    logic [7:0] vector_q;
    logic [63:0] addr_q;

    // Mask of address bits at or above the host address width.
    function automatic logic [63:0] above_width(input logic [6:0] w);
        logic [63:0] m;
        m = '1;
        if (w < 7'h40) begin
            m = 64'hFFFF_FFFF_FFFF_FFFF << w;
        end else begin
            m = '0;
        end
        return m;
    endfunction : above_width

    assign present = entry_in[pid_pkg::PRESENT_BIT];
    assign posting_mode_bit = entry_in[pid_pkg::POSTING_MODE_BIT];
    assign urgent_flag = entry_in[pid_pkg::URGENT_BIT];
    assign origin_check_type = entry_in[pid_pkg::CHECK_MSB:pid_pkg::CHECK_LSB];
    assign origin_check_qualifier =
        entry_in[pid_pkg::QUAL_MSB:pid_pkg::QUAL_LSB];
    assign originator_identifier =
        entry_in[pid_pkg::ORIG_ID_MSB:pid_pkg::ORIG_ID_LSB];
    assign post_desc_addr_low =
        entry_in[pid_pkg::DESC_LO_MSB:pid_pkg::DESC_LO_LSB];
    assign post_desc_addr_high =
        entry_in[pid_pkg::DESC_HI_MSB:pid_pkg::DESC_HI_LSB];
    assign addr_full = {post_desc_addr_high, post_desc_addr_low,
        6'h0};
    assign width_mask = above_width(host_address_width_in);
    assign guest_vector =
        entry_in[pid_pkg::VECTOR_MSB:pid_pkg::VECTOR_LSB];

    // Bus-range entries hold the first bus high and the last bus low.
    assign req_bus = requester_id_in[pid_pkg::BUS_MSB:pid_pkg::BUS_LSB];
    assign first_bus =
        originator_identifier[pid_pkg::BUS_MSB:pid_pkg::BUS_LSB];
    assign last_bus =
        originator_identifier[pid_pkg::LAST_BUS_MSB:pid_pkg::LAST_BUS_LSB];

    // Phantom-function qualifiers drop low identifier bits from the compare.
    assign rid_match =
        ((originator_identifier ^ requester_id_in) & id_mask) ==
        16'h0000;
    assign bus_in_range =
        (req_bus >= first_bus) && (req_bus <= last_bus);

    always_comb begin
        case (origin_check_qualifier)
            2'b00: id_mask = 16'hFFFF;
            2'b01: id_mask = 16'hFFFB;
            2'b10: id_mask = 16'hFFF9;
            2'b11: id_mask = 16'hFFF8;
            default: id_mask = 16'hFFFF;
        endcase
    end

    // Check type 11b fails here and is reported as malformed by priority.
    always_comb begin
        case (origin_check_type)
            pid_pkg::PID_CHECK_NONE: src_ok = 1'b1;
            pid_pkg::PID_CHECK_RID: src_ok = rid_match;
            pid_pkg::PID_CHECK_BUS: src_ok = bus_in_range;
            default: src_ok = 1'b0;
        endcase
    end

    // Reserved 11b check type is treated as a malformed entry.
    always_comb begin
        rsvd_bad =
            (entry_in[pid_pkg::RSVD_MID_MSB:pid_pkg::RSVD_MID_LSB] != '0) ||
            (entry_in[pid_pkg::RSVD_LO_MSB:pid_pkg::RSVD_LO_LSB] != '0) ||
            (entry_in[pid_pkg::RSVD_HI_MSB:pid_pkg::RSVD_HI_LSB] != '0) ||
            ((addr_full & width_mask) != '0) ||
            (origin_check_type == pid_pkg::PID_CHECK_RSVD);
        if (!posting_supported_cap_in &&
                (posting_mode_bit || urgent_flag)) begin
            rsvd_bad = 1'b1;
        end
    end

    // Priority: absent entry, then malformed entry, then failed origin check.
    always_comb begin
        if (!present) begin
            res_d = pid_pkg::PID_RES_BLOCKED;
        end else if (rsvd_bad) begin
            res_d = pid_pkg::PID_RES_FORMAT_FAULT;
        end else if (!src_ok) begin
            res_d = pid_pkg::PID_RES_SRC_FAULT;
        end else begin
            res_d = pid_pkg::PID_RES_OK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            res_valid_q <= 1'b0;
            result_q <= 2'b00;
        end else begin
            res_valid_q <= req_valid_in;
            if (req_valid_in) begin
                result_q <= res_d;
            end
        end
    end

    // Decoded fields only leave the block for a clean valid entry.
    assign deliver = (res_d == pid_pkg::PID_RES_OK);
    assign post_ok = deliver && posting_mode_bit;

    // Faulted or blocked lookups clear every decoded flag to zero.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            posted_q <= 1'b0;
            remapped_q <= 1'b0;
            urgent_q <= 1'b0;
        end else if (req_valid_in) begin
            posted_q <= post_ok;
            remapped_q <= deliver && !posting_mode_bit;
            urgent_q <= post_ok && urgent_flag;
        end
    end

    // Remapped entries use another layout, so the vector reads as zero.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            vector_q <= 8'h00;
        end else if (req_valid_in) begin
            if (post_ok) begin
                vector_q <= guest_vector;
            end else begin
                vector_q <= 8'h00;
            end
        end
    end

    // The descriptor address leaves the block only for a posted entry.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            addr_q <= 64'h0000_0000_0000_0000;
        end else if (req_valid_in) begin
            if (post_ok) begin
                addr_q <= addr_full;
            end else begin
                addr_q <= 64'h0000_0000_0000_0000;
            end
        end
    end

    assign res_valid_out = res_valid_q;
    assign result_out = result_q;
    assign posted_out = posted_q;
    assign remapped_out = remapped_q;
    assign urgent_flag_out = urgent_q;
    assign guest_vector_out = vector_q;
    assign post_desc_addr_out = addr_q;
endmodule : pid_entry_decode

//--- bench/pid_props.sv
// Checker for the posted entry decoder's answers.
// Assumes it is bound to pid_entry_decode, one clock domain.
`timescale 1ns/1ns
module pid_props (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic req_valid_in,
    input wire logic [127:0] entry_in,
    input wire logic [15:0] requester_id_in,
    input wire logic posting_supported_cap_in,
    input wire logic [6:0] host_address_width_in,
    input wire logic res_valid_out,
    input wire logic [1:0] result_out,
    input wire logic posted_out,
    input wire logic remapped_out,
    input wire logic urgent_flag_out,
    input wire logic [7:0] guest_vector_out,
    input wire logic [63:0] post_desc_addr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic live = req_valid_in && entry_in[0];
    answer_delay_a: assert property (req_valid_in |=> res_valid_out)
        else $error("no answer one cycle after a request");
    blocked_entry_a: assert property (req_valid_in && !entry_in[0]
        |=> result_out == 2'h1 && !posted_out) else $error("not blocked");
    reserved_bits_a: assert property (live && (|entry_in[37:24]
        || |entry_in[13:12]) |=> result_out == 2'h3) else $error("rsvd");
    no_posting_a: assert property (live && !posting_supported_cap_in
        && |entry_in[15:14] |=> result_out == 2'h3) else $error("cap");
    bus_range_a: assert property (live && entry_in[83:82] == 2'h2
        && (requester_id_in[15:8] < entry_in[79:72]
        || requester_id_in[15:8] > entry_in[71:64]) |=> result_out[1])
        else $error("bus outside range accepted");
    guest_vector_a: assert property (res_valid_out && posted_out |->
        guest_vector_out == $past(entry_in[23:16])) else $error("vector");
    desc_addr_a: assert property (res_valid_out && posted_out |->
        post_desc_addr_out == {$past(entry_in[127:96]),
        $past(entry_in[63:38]), 6'h00}) else $error("address");
    urgent_flag_a: assert property (res_valid_out |->
        urgent_flag_out == (posted_out && $past(entry_in[14])))
        else $error("urgent");
    cover property (res_valid_out && urgent_flag_out);
    cover property (res_valid_out && result_out == 2'h2);
    cover property (res_valid_out && remapped_out);
    cover property (res_valid_out && result_out == 2'h0 && posted_out);
endmodule : pid_props
bind pid_entry_decode pid_props u_chk (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .req_valid_in(req_valid_in),
    .entry_in(entry_in),
    .requester_id_in(requester_id_in),
    .posting_supported_cap_in(posting_supported_cap_in),
    .host_address_width_in(host_address_width_in),
    .res_valid_out(res_valid_out),
    .result_out(result_out),
    .posted_out(posted_out),
    .remapped_out(remapped_out),
    .urgent_flag_out(urgent_flag_out),
    .guest_vector_out(guest_vector_out),
    .post_desc_addr_out(post_desc_addr_out)
);

//--- bench/pid_endpoint.sv
// Endpoint model issuing one interrupt request per go pulse.
// Assumes go_in is driven just after a rising edge.
`timescale 1ns/1ns
module pid_endpoint (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [127:0] entry_in,
    input wire logic [15:0] rid_in,
    output logic req_valid_out = 1'b0,
    output logic [127:0] entry_out = '0,
    output logic [15:0] rid_out = '0
);
    // Idle lines flip so stale data never passes for a request.
    always @(posedge clk_in) begin
        req_valid_out <= go_in;
        entry_out <= go_in ? entry_in : ~entry_out;
        rid_out <= go_in ? rid_in : ~rid_out;
    end
endmodule : pid_endpoint

//--- bench/test_pid_entry_decode.sv
// Bench for the posted entry decoder: sequences of lookups.
// Assumes pid_endpoint issues each lookup a cycle after go.
`timescale 1ns/1ns
module test_pid_entry_decode;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic go = 1'b0;
    logic cap = 1'b1;
    logic [6:0] addr_width = pid_pkg::ADDR_WIDTH_RESET;
    logic [127:0] e_q = '0;
    logic [127:0] ent;
    logic [15:0] r_q = '0;
    logic [15:0] rid;
    logic req, rv, po, rm, ug;
    logic [1:0] res;
    logic [7:0] vec;
    logic [63:0] adr;
    logic [15:0] bus_rid [4] = '{16'h0fff, 16'h1000, 16'h30ff, 16'h3100};
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 clk_in = ~clk_in;
    pid_endpoint ep (.clk_in, .go_in(go), .entry_in(e_q), .rid_in(r_q),
        .req_valid_out(req), .entry_out(ent), .rid_out(rid));
    pid_entry_decode dut (.clk_in, .nrst_in, .req_valid_in(req),
        .entry_in(ent), .requester_id_in(rid),
        .posting_supported_cap_in(cap), .host_address_width_in(addr_width),
        .res_valid_out(rv), .result_out(res), .posted_out(po),
        .remapped_out(rm), .urgent_flag_out(ug), .guest_vector_out(vec),
        .post_desc_addr_out(adr));
    task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // Descriptors sit on 64-byte boundaries, a whole cache line each.
    function automatic logic [127:0] mk(logic [3:0] cq, logic [15:0] oid,
            logic [23:0] lo);
        return {32'h0000_1234, 12'h000, cq, oid, 26'h2ab_cdef, 14'h0, lo};
    endfunction : mk
    task automatic run(logic [127:0] e, logic [15:0] r, logic [1:0] x);
        logic pm;
        logic rm_exp;
        pm = x == 2'h0 && e[15];
        rm_exp = x == 2'h0 && !e[15];
        @(posedge clk_in);
        go <= 1'b1;
        e_q <= e;
        r_q <= r;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("answer", {rv, res}, {1'b1, x});
        chk("flags", {po, rm, ug}, {pm, rm_exp, pm && e[14]});
        chk("vector", vec, pm ? e[23:16] : 8'h00);
        chk("address", adr, pm ? {e[127:96], e[63:38], 6'h00} : 0);
        @(posedge clk_in);
        #1;
        chk("pulse", {rv, res}, {1'b0, x});
    endtask : run
    task automatic results();
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        run(mk(4'h0, 16'h0, 24'h5a_c001), 16'hffff, 2'h0);
        @(posedge clk_in) nrst_in <= 1'b0;
        @(posedge clk_in) nrst_in <= 1'b1;
        #1;
        chk("reset", {rv, res, po, rm, ug, vec}, 64'h0);
        chk("reset address", adr, 64'h0);
        run(mk(4'h0, 16'h0, 24'h5a_0001), 16'hffff, 2'h0);
        run(mk(4'hf, 16'h0, 24'h5a_f000), 16'hffff, 2'h1);
        run(mk(4'h0, 16'h0, 24'h5a_b001), 16'h0, 2'h3);
        run(mk(4'h0, 16'h0, 24'h5a_8001) | 128'h4000_0000, 16'h0, 2'h3);
        run(mk(4'hc, 16'h0, 24'h5a_8001), 16'h0, 2'h3);
        @(posedge clk_in) addr_width <= 7'h28;
        run(mk(4'h0, 16'h0, 24'h5a_8001), 16'h0, 2'h3);
        @(posedge clk_in) addr_width <= pid_pkg::ADDR_WIDTH_RESET;
        @(posedge clk_in) cap <= 1'b0;
        run(mk(4'h0, 16'h0, 24'h5a_4001), 16'h0, 2'h3);
        run(mk(4'h0, 16'h0, 24'h5a_0001), 16'h0, 2'h0);
        @(posedge clk_in) cap <= 1'b1;
        for (int q = 0; q < 4; q++) begin
            for (int b = 0; b < 5; b++) begin
                run(mk({2'h1, 2'(q)}, 16'h5a5a, 24'h5a_8001),
                    16'h5a5a ^ (b == 4 ? 16'h0 : 16'h1 << b),
                    (b == 4 || (b < 3 && b + q > 2)) ? 2'h0 : 2'h2);
            end
        end
        for (int i = 0; i < 4; i++) begin
            run(mk(4'h8, 16'h1030, 24'h5a_8001), bus_rid[i],
                (i == 1 || i == 2) ? 2'h0 : 2'h2);
        end
        results();
    end
endmodule : test_pid_entry_decode
